// [rtl/pca_pkg.sv]
// What this block does
// - each slot has an eight-bit pulses-per-internal-sample field
// - each slot has a three-bit field choosing how many samples combine
// - with combining active, results come at sample rate over sample count
// - pulses per result equal pulse count times samples combined
// - photodiode reverse bias applies only while its enable bit is one
// - bias level per slot: upper two bits slot B, lower two slot A
// - each slot has a four-bit polarity pattern, bit n for pulse n+1
// - the same four-entry pattern repeats every four pulses, restarting at pulse one each sample
// - pattern bit zero means normal integration, one means reversed
// - pulse results are added or subtracted per math fields
// - one register holds four two-bit math fields for both slots
// - math code 01 adds first pulse of pair, subtracts second
// - pattern value A reverses pulses two and four only
// - math codes: 00 add both, 01 add-sub, 10 sub-add, 11 sub both
package pca_pkg;
    localparam int NUM_SLOTS = 2;
    localparam int PULSE_W   = 14;
    localparam int ACC_W     = 32;
    localparam int REG_W     = 16;
    localparam int IDX_W     = 8;
    localparam int PCNT_W    = 8;
    localparam int PCNT_LSB  = 8;
    localparam int AVG_W     = 3;
    localparam int ORDER_W   = 4;
    localparam int ORDER_LSB = 0;
    localparam int MATH_W    = 2;
    localparam int BIAS_W    = 2;
    localparam int BIAS_EN_BIT = 7;
    localparam int AVG_LSB   [NUM_SLOTS] = '{4, 8};
    localparam int BIAS_LSB  [NUM_SLOTS] = '{8, 10};
    localparam int M12_LSB   [NUM_SLOTS] = '{1, 5};
    localparam int M34_LSB   [NUM_SLOTS] = '{8, 10};
    // software registers, kept in one array
    localparam int NUM_CFG    = 7;
    localparam int CFG_AVG    = 0;
    localparam int CFG_ORD_A  = 1;
    localparam int CFG_PCNT_A = 3;
    localparam int CFG_BIAS   = 5;
    localparam int CFG_MATH   = 6;
    localparam logic [7:0] CFG_IDX [NUM_CFG] =
        '{8'h15, 8'h17, 8'h1D, 8'h31, 8'h36, 8'h54, 8'h58};
    localparam logic [15:0] CFG_MASK [NUM_CFG] =
        '{16'h0770, 16'h000F, 16'h000F, 16'hFF00, 16'hFF00, 16'h0F80, 16'h0F66};
    localparam logic [15:0] CFG_RST [NUM_CFG] =
        '{16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0100, 16'h0000, 16'h0000};
    localparam logic [7:0] RES_A_IDX = 8'h60;
    localparam logic [7:0] RES_B_IDX = 8'h61;
    localparam logic [7:0] STAT_IDX  = 8'h62;
    localparam logic [1:0] MATH_ADD_SUB = 2'h1;
    localparam logic [3:0] ORDER_ALT    = 4'hA;
endpackage

// [rtl/pca_cfg_regs.sv]
`timescale 1ns/10ps
module pca_cfg_regs (
    input  wire logic                                        clk_in,
    input  wire logic                                        rst_b_in,
    input  wire logic                                        wr_en_in,
    input  wire logic [pca_pkg::NUM_CFG-1:0]                 wr_sel_in,
    input  wire logic [1:0]                                  strb_in,
    input  wire logic [pca_pkg::REG_W-1:0]                   wdata_in,
    output logic      [pca_pkg::NUM_CFG-1:0][pca_pkg::REG_W-1:0] cfg_out
);
    import pca_pkg::*;

    logic [NUM_CFG-1:0][REG_W-1:0] cfg_ff;
    logic [REG_W-1:0]              lane_mask;

    // reserved bits never store, so they read back as zero
    assign lane_mask = {{8{strb_in[1]}}, {8{strb_in[0]}}};
    assign cfg_out   = cfg_ff;

    genvar i;
    generate
        for (i = 0; i < NUM_CFG; i++) begin : g_reg
            logic [REG_W-1:0] wmask;
            assign wmask = lane_mask & CFG_MASK[i];
            // byte-lane write, one word per register
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    cfg_ff[i] <= CFG_RST[i];
                end else if (wr_en_in && wr_sel_in[i]) begin
                    cfg_ff[i] <= (cfg_ff[i] & ~wmask) | (wdata_in & wmask);
                end
            end
        end
    endgenerate
endmodule

// [rtl/pca_slot_accum.sv]
`timescale 1ns/10ps
module pca_slot_accum (
    input  wire logic                               clk_in,
    input  wire logic                               rst_b_in,
    input  wire logic                               start_in,
    input  wire logic                               pulse_valid_in,
    input  wire logic [pca_pkg::PULSE_W-1:0]        pulse_data_in,
    input  wire logic [pca_pkg::PCNT_W-1:0]         pcnt_in,
    input  wire logic [pca_pkg::AVG_W-1:0]          avg_in,
    input  wire logic [pca_pkg::ORDER_W-1:0]        pattern_in,
    input  wire logic [pca_pkg::MATH_W-1:0]         math12_in,
    input  wire logic [pca_pkg::MATH_W-1:0]         math34_in,
    output logic      [1:0]                         pos_out,
    output logic                                    reverse_out,
    output logic                                    subtract_out,
    output logic                                    sample_done_out,
    output logic                                    result_valid_out,
    output logic      [pca_pkg::ACC_W-1:0]          result_out
);
    import pca_pkg::*;

    logic [1:0]       pos_ff,  nxt_pos;
    logic [8:0]       cnt_ff,  nxt_cnt;
    logic [8:0]       samp_ff, nxt_samp;
    logic [ACC_W-1:0] sacc_ff, nxt_sacc;
    logic [ACC_W-1:0] oacc_ff, nxt_oacc;
    logic [ACC_W-1:0] res_ff,  nxt_res;
    logic             rev_ff, done_ff, nxt_done, valid_ff, nxt_valid;

    // zero pulse count is taken as one so a sample always ends
    wire [8:0]       eff_pcnt   = (pcnt_in == '0) ? 9'h001 : {1'b0, pcnt_in};
    wire [8:0]       eff_avg    = 9'h001 << avg_in;
    wire [1:0]       pair_code  = pos_ff[1] ? math34_in : math12_in;
    wire             sub        = pos_ff[0] ? pair_code[0] : pair_code[1];
    wire [ACC_W-1:0] mag        = {{(ACC_W-PULSE_W){1'b0}}, pulse_data_in};
    wire [ACC_W-1:0] term       = sub ? (~mag + 32'h0000_0001) : mag;
    wire [ACC_W-1:0] sample_sum = sacc_ff + term;
    wire [ACC_W-1:0] out_sum    = oacc_ff + sample_sum;
    // >= so a count lowered mid-sample still closes it
    wire             last_pulse = (cnt_ff + 9'h001) >= eff_pcnt;
    wire             last_samp  = (samp_ff + 9'h001) >= eff_avg;

    assign pos_out          = pos_ff;
    assign reverse_out      = rev_ff;
    assign subtract_out     = sub;
    assign sample_done_out  = done_ff;
    assign result_valid_out = valid_ff;
    assign result_out       = res_ff;

    // pulse sequencing and two-level accumulation
    always_comb begin
        nxt_pos   = pos_ff;
        nxt_cnt   = cnt_ff;
        nxt_samp  = samp_ff;
        nxt_sacc  = sacc_ff;
        nxt_oacc  = oacc_ff;
        nxt_res   = res_ff;
        nxt_done  = 1'b0;
        nxt_valid = 1'b0;
        if (start_in) begin
            nxt_pos  = 2'h0;
            nxt_cnt  = 9'h000;
            nxt_sacc = '0;
            nxt_samp = 9'h000;
            nxt_oacc = '0;
        end else if (pulse_valid_in) begin
            if (last_pulse) begin
                nxt_pos  = 2'h0;
                nxt_cnt  = 9'h000;
                nxt_sacc = '0;
                nxt_done = 1'b1;
                if (last_samp) begin
                    nxt_samp  = 9'h000;
                    nxt_oacc  = '0;
                    nxt_res   = out_sum;
                    nxt_valid = 1'b1;
                end else begin
                    nxt_samp = samp_ff + 9'h001;
                    nxt_oacc = out_sum;
                end
            end else begin
                nxt_pos  = pos_ff + 2'h1;
                nxt_cnt  = cnt_ff + 9'h001;
                nxt_sacc = sample_sum;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pos_ff   <= 2'h0;
            cnt_ff   <= 9'h000;
            samp_ff  <= 9'h000;
            sacc_ff  <= '0;
            oacc_ff  <= '0;
            res_ff   <= '0;
            rev_ff   <= 1'b0;
            done_ff  <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            pos_ff   <= nxt_pos;
            cnt_ff   <= nxt_cnt;
            samp_ff  <= nxt_samp;
            sacc_ff  <= nxt_sacc;
            oacc_ff  <= nxt_oacc;
            res_ff   <= nxt_res;
            rev_ff   <= pattern_in[nxt_pos];
            done_ff  <= nxt_done;
            valid_ff <= nxt_valid;
        end
    end
endmodule

// [rtl/pca_top.sv]
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module pca_top (
    input  wire logic                                   CLK_IN,
    input  wire logic                                   RST_B_IN,
    input  wire logic                                   PSEL_IN,
    input  wire logic                                   PENABLE_IN,
    input  wire logic                                   PWRITE_IN,
    input  wire logic [11:0]                            PADDR_IN,
    input  wire logic [31:0]                            PWDATA_IN,
    input  wire logic [3:0]                             PSTRB_IN,
    output logic      [31:0]                            PRDATA_OUT,
    output logic                                        PREADY_OUT,
    output logic                                        PSLVERR_OUT,
    input  wire logic                                   PULSE_VALID_IN,
    input  wire logic                                   PULSE_SLOT_IN,
    input  wire logic [pca_pkg::PULSE_W-1:0]            PULSE_DATA_IN,
    input  wire logic [pca_pkg::NUM_SLOTS-1:0]          SAMPLE_START_IN,
    output logic      [pca_pkg::NUM_SLOTS-1:0]          REVERSE_OUT,
    output logic      [pca_pkg::NUM_SLOTS-1:0]          RESULT_VALID_OUT,
    output logic      [pca_pkg::ACC_W-1:0]              RESULT_A_OUT,
    output logic      [pca_pkg::ACC_W-1:0]              RESULT_B_OUT,
    output logic                                        PD_BIAS_EN_OUT,
    output logic      [pca_pkg::BIAS_W-1:0]             BIAS_A_LEVEL_OUT,
    output logic      [pca_pkg::BIAS_W-1:0]             BIAS_B_LEVEL_OUT
);
    import pca_pkg::*;

    logic [NUM_CFG-1:0][REG_W-1:0] cfg;
    logic [NUM_CFG-1:0]            cfg_hit;
    logic [31:0]                   rd_chain [NUM_CFG+1];
    logic [1:0]                    pos_w     [NUM_SLOTS];
    logic [ORDER_W-1:0]            pattern_w [NUM_SLOTS];
    logic [PCNT_W-1:0]             pcnt_w    [NUM_SLOTS];
    logic [AVG_W-1:0]              avg_w     [NUM_SLOTS];
    logic [MATH_W-1:0]             m12_w     [NUM_SLOTS];
    logic [MATH_W-1:0]             m34_w     [NUM_SLOTS];
    logic [ACC_W-1:0]              result_w  [NUM_SLOTS];
    logic [NUM_SLOTS-1:0]          sub_w;
    logic [NUM_SLOTS-1:0]          done_w;
    logic [31:0]                   prdata_ff;
    logic                          pslverr_ff;
    logic                          bias_en_ff;
    logic [BIAS_W-1:0]             bias_a_ff, bias_b_ff;

    // apb decode: word index is byte address over four
    wire [IDX_W-1:0] idx      = PADDR_IN[9:2];
    wire             addr_ok  = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN[11:10] == 2'h0);
    wire             setup    = PSEL_IN && !PENABLE_IN;
    wire             wr_take  = PSEL_IN && PENABLE_IN && PWRITE_IN;
    wire             res_a_hit = addr_ok && (idx == RES_A_IDX);
    wire             res_b_hit = addr_ok && (idx == RES_B_IDX);
    wire             stat_hit  = addr_ok && (idx == STAT_IDX);
    wire             any_hit   = (|cfg_hit) || res_a_hit || res_b_hit || stat_hit;
    wire [31:0]      stat_word = {26'h0, REVERSE_OUT, pos_w[1], pos_w[0]};
    wire [31:0]      rd_word   = rd_chain[NUM_CFG]
                               | (res_a_hit ? result_w[0] : 32'h0000_0000)
                               | (res_b_hit ? result_w[1] : 32'h0000_0000)
                               | (stat_hit  ? stat_word   : 32'h0000_0000);

    assign rd_chain[0] = 32'h0000_0000;

    // per-register hit and read mux chain
    genvar i;
    generate
        for (i = 0; i < NUM_CFG; i++) begin : g_dec
            assign cfg_hit[i]    = addr_ok && (idx == CFG_IDX[i]);
            assign rd_chain[i+1] = rd_chain[i] | (cfg_hit[i] ? {16'h0000, cfg[i]} : 32'h0000_0000);
        end
    endgenerate

    // zero wait states: every access phase completes at once
    assign PREADY_OUT  = 1'b1;
    assign PRDATA_OUT  = prdata_ff;
    assign PSLVERR_OUT = pslverr_ff;

    // read data latched in setup so it stands through the access phase
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff  <= PWRITE_IN ? 32'h0000_0000 : rd_word;
            pslverr_ff <= !any_hit;
        end
    end

    pca_cfg_regs u_regs (
        .clk_in    (CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_en_in  (wr_take),
        .wr_sel_in (cfg_hit),
        .strb_in   (PSTRB_IN[1:0]),
        .wdata_in  (PWDATA_IN[15:0]),
        .cfg_out   (cfg)
    );

    // one accumulator per time slot
    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
            logic pvalid;
            assign pcnt_w[s]    = cfg[CFG_PCNT_A+s][PCNT_LSB +: PCNT_W];
            assign avg_w[s]     = cfg[CFG_AVG][AVG_LSB[s] +: AVG_W];
            assign pattern_w[s] = cfg[CFG_ORD_A+s][ORDER_LSB +: ORDER_W];
            assign m12_w[s]     = cfg[CFG_MATH][M12_LSB[s] +: MATH_W];
            assign m34_w[s]     = cfg[CFG_MATH][M34_LSB[s] +: MATH_W];
            assign pvalid       = PULSE_VALID_IN && (PULSE_SLOT_IN == 1'(s));
            pca_slot_accum u_acc (
                .clk_in           (CLK_IN),
                .rst_b_in         (RST_B_IN),
                .start_in         (SAMPLE_START_IN[s]),
                .pulse_valid_in   (pvalid),
                .pulse_data_in    (PULSE_DATA_IN),
                .pcnt_in          (pcnt_w[s]),
                .avg_in           (avg_w[s]),
                .pattern_in       (pattern_w[s]),
                .math12_in        (m12_w[s]),
                .math34_in        (m34_w[s]),
                .pos_out          (pos_w[s]),
                .reverse_out      (REVERSE_OUT[s]),
                .subtract_out     (sub_w[s]),
                .sample_done_out  (done_w[s]),
                .result_valid_out (RESULT_VALID_OUT[s]),
                .result_out       (result_w[s])
            );
        end
    endgenerate

    assign RESULT_A_OUT = result_w[0];
    assign RESULT_B_OUT = result_w[1];

    // bias level forced to zero whenever the enable is clear
    wire             bias_en  = cfg[CFG_BIAS][BIAS_EN_BIT];
    wire [BIAS_W-1:0] lvl_a   = cfg[CFG_BIAS][BIAS_LSB[0] +: BIAS_W];
    wire [BIAS_W-1:0] lvl_b   = cfg[CFG_BIAS][BIAS_LSB[1] +: BIAS_W];

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            bias_en_ff <= 1'b0;
            bias_a_ff  <= '0;
            bias_b_ff  <= '0;
        end else begin
            bias_en_ff <= bias_en;
            bias_a_ff  <= bias_en ? lvl_a : '0;
            bias_b_ff  <= bias_en ? lvl_b : '0;
        end
    end

    assign PD_BIAS_EN_OUT   = bias_en_ff;
    assign BIAS_A_LEVEL_OUT = bias_a_ff;
    assign BIAS_B_LEVEL_OUT = bias_b_ff;

    // checking helpers: delayed pattern, counts between results
    logic [ORDER_W-1:0] pat_d_ff  [NUM_SLOTS];
    logic [15:0]        npulse_ff [NUM_SLOTS];
    logic [8:0]         nsamp_ff  [NUM_SLOTS];

    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : g_chk
            wire        pv      = PULSE_VALID_IN && (PULSE_SLOT_IN == 1'(s));
            wire [15:0] eff_p   = (pcnt_w[s] == '0) ? 16'h0001 : {8'h00, pcnt_w[s]};
            wire [15:0] eff_a   = 16'h0001 << avg_w[s];
            wire [31:0] want_p  = eff_p * eff_a;
            wire [8:0]  want_s  = 9'h001 << avg_w[s];

            always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
                if (!RST_B_IN) begin
                    pat_d_ff[s]  <= '0;
                    npulse_ff[s] <= 16'h0000;
                    nsamp_ff[s]  <= 9'h000;
                end else begin
                    pat_d_ff[s] <= pattern_w[s];
                    if (SAMPLE_START_IN[s] || RESULT_VALID_OUT[s]) begin
                        npulse_ff[s] <= SAMPLE_START_IN[s] ? 16'h0000 : {15'h0000, pv};
                        nsamp_ff[s]  <= 9'h000;
                    end else begin
                        npulse_ff[s] <= npulse_ff[s] + {15'h0000, pv};
                        nsamp_ff[s]  <= nsamp_ff[s] + {8'h00, done_w[s]};
                    end
                end
            end

            a_result_rate: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                (RESULT_VALID_OUT[s] && $stable(avg_w[s]) && $past(!SAMPLE_START_IN[s]))
                |-> (nsamp_ff[s] + 9'h001) == want_s)
                else $error("result emitted after wrong sample count");

            a_result_pulses: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                (RESULT_VALID_OUT[s] && $stable(cfg) && $past(!RESULT_VALID_OUT[s])
                 && $past(!SAMPLE_START_IN[s]))
                |-> {16'h0000, npulse_ff[s]} == want_p)
                else $error("pulse total per result wrong");

            a_pattern_order: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                ##1 REVERSE_OUT[s] == pat_d_ff[s][pos_w[s]])
                else $error("reverse flag does not follow pattern bit");

            a_pattern_wrap: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                (pv && !SAMPLE_START_IN[s] && !done_w[s] && pos_w[s] == 2'h3
                 && ({1'b0, npulse_ff[s]} + 17'h00001) < {1'b0, eff_p})
                |=> pos_w[s] == 2'h0)
                else $error("pattern position did not wrap after pulse four");

            a_alt_pattern: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                (pat_d_ff[s] == ORDER_ALT && $stable(pattern_w[s]))
                |-> REVERSE_OUT[s] == pos_w[s][0])
                else $error("alternate pattern reverses wrong pulses");

            a_math_addsub: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                (m12_w[s] == MATH_ADD_SUB && pos_w[s][1] == 1'b0)
                |-> sub_w[s] == pos_w[s][0])
                else $error("add-subtract code gives wrong sign");

            a_math_codes: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                sub_w[s] == (pos_w[s][0] ? (pos_w[s][1] ? m34_w[s][0] : m12_w[s][0])
                                         : (pos_w[s][1] ? m34_w[s][1] : m12_w[s][1])))
                else $error("math code decode wrong");

            a_pos_restart: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
                SAMPLE_START_IN[s] |=> (pos_w[s] == 2'h0) && !RESULT_VALID_OUT[s])
                else $error("position not back to pulse one after start");
        end
    endgenerate

    a_bias_gate: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !bias_en |=> (BIAS_A_LEVEL_OUT == '0) && (BIAS_B_LEVEL_OUT == '0) && !PD_BIAS_EN_OUT)
        else $error("bias level present while disabled");

    a_bias_level: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        bias_en |=> BIAS_B_LEVEL_OUT == $past(lvl_b) && BIAS_A_LEVEL_OUT == $past(lvl_a))
        else $error("bias level taken from wrong field");

    a_pcnt_read: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (setup && !PWRITE_IN && cfg_hit[CFG_PCNT_A])
        |=> PRDATA_OUT[15:8] == $past(pcnt_w[0]) && PRDATA_OUT[7:0] == 8'h00)
        else $error("pulse count readback wrong");

    a_avg_read: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (setup && !PWRITE_IN && cfg_hit[CFG_AVG])
        |=> PRDATA_OUT[10:8] == $past(avg_w[1]) && PRDATA_OUT[6:4] == $past(avg_w[0]))
        else $error("averaging field readback wrong");

    a_math_read: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (setup && !PWRITE_IN && cfg_hit[CFG_MATH])
        |=> PRDATA_OUT[11:8] == {$past(m34_w[1]), $past(m34_w[0])}
            && PRDATA_OUT[6:5] == $past(m12_w[1]) && PRDATA_OUT[2:1] == $past(m12_w[0]))
        else $error("math field readback wrong");

    a_sign_add: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (m12_w[0] == 2'h0 && m34_w[0] == 2'h0) |-> !sub_w[0])
        else $error("add-both code subtracts");

    c_result_a: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        RESULT_VALID_OUT[0] && avg_w[0] != '0);
    c_result_b: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        RESULT_VALID_OUT[1]);
    c_chop_wrap: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        pattern_w[0] == ORDER_ALT && pos_w[0] == 2'h3 ##1 pos_w[0] == 2'h0);
    c_bias_on: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        PD_BIAS_EN_OUT && BIAS_A_LEVEL_OUT == 2'h2);
endmodule

// [dv/test_pulse_chop_accumulator.sv]
`timescale 1ns/10ps
module test_pulse_chop_accumulator;
    import pca_pkg::*;
    logic               clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, pv = 0, slot = 0, err, prdy, perr, b_en;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, rd, prdata, res_a, res_b, expv;
    logic [PULSE_W-1:0] pdata = '0;
    logic [1:0]         start = 2'h0, rev, rvld, b_a, b_b;
    int                 error_cnt = 0, num_checks = 0, seed = 94852;
    logic [31:0]        exp_q[$], exp_qb[$], expb;
    logic [31:0]        last_s [2];
    // half period of the 40 MHz clock
    always #12.5 clk = ~clk;
    pca_top DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF), .PRDATA_OUT(prdata), .PREADY_OUT(prdy),
        .PSLVERR_OUT(perr), .PULSE_VALID_IN(pv), .PULSE_SLOT_IN(slot), .PULSE_DATA_IN(pdata),
        .SAMPLE_START_IN(start), .REVERSE_OUT(rev), .RESULT_VALID_OUT(rvld), .RESULT_A_OUT(res_a),
        .RESULT_B_OUT(res_b), .PD_BIAS_EN_OUT(b_en), .BIAS_A_LEVEL_OUT(b_a), .BIAS_B_LEVEL_OUT(b_b));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prdata; err = perr; psel <= 0; pen <= 0;
    endtask
    // twelve back-to-back pulses: two samples of six, summed
    task run(input logic [1:0] m, input logic sl);
        logic [31:0] s;
        logic [PULSE_W-1:0] d;
        int p;
        s = 0;
        @(posedge clk); start <= 2'h1 << sl;
        @(posedge clk); start <= 2'h0;
        for (int k = 0; k <= 12; k++) begin
            @(posedge clk);
            d = PULSE_W'($random(seed));
            p = (k % 6) % 4;
            pv <= (k < 12); pdata <= d; slot <= sl;
            if (k < 12) s = ((p % 2) ? m[0] : m[1]) ? s - d : s + d;
            #1 if (k > 0) chk({31'h0, rev[sl]}, {31'h0, ORDER_ALT[p]});
        end
        if (sl) exp_qb.push_back(s);
        else exp_q.push_back(s);
        last_s[sl] = s;
    endtask
    // result watchers take the oldest expected sum of their slot
    always @(posedge clk) if (rvld[0] === 1'b1) begin
        expv = exp_q.size() ? exp_q.pop_front() : ~res_a;
        chk(res_a, expv);
    end
    always @(posedge clk) if (rvld[1] === 1'b1) begin
        expb = exp_qb.size() ? exp_qb.pop_front() : ~res_b;
        chk(res_b, expb);
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #50000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1;
        apb(0, 12'h0C4, 0); chk(rd, 32'h0000_0100);
        apb(0, 12'h3FC, 0); chk({31'h0, err}, 32'h1);
        apb(1, 12'h150, 32'h0000_0680); repeat (2) @(posedge clk); #1 chk({b_en, b_b, b_a}, 5'h16);
        apb(1, 12'h150, 32'h0000_0600); repeat (2) @(posedge clk); #1 chk({b_en, b_b, b_a}, 5'h00);
        $display("register and bias test done");
        // chop setup: even pulse counts; adc offsets sit upstream and stay zero
        apb(1, 12'h054, 32'h0000_0110);
        apb(1, 12'h0C4, 32'h0000_0600); apb(1, 12'h0D8, 32'h0000_0600);
        apb(1, 12'h05C, 32'h0000_000A); apb(1, 12'h074, 32'h0000_000A);
        apb(0, 12'h05C, 0); chk(rd, 32'h0000_000A);
        apb(0, 12'h074, 0); chk(rd, 32'h0000_000A);
        for (int m = 0; m < 4; m++) begin
            apb(1, 12'h160, (m << 1) | (m << 5) | (m << 8) | (m << 10));
            run(m[1:0], 1'b0);
            run(m[1:0], 1'b1);
        end
        repeat (4) @(posedge clk);
        apb(0, 12'h180, 0); chk(rd, last_s[0]);
        apb(0, 12'h184, 0); chk(rd, last_s[1]);
        apb(0, 12'h188, 0); chk(rd, 32'h0000_0000);
        chk(exp_q.size() + exp_qb.size(), 0);
        $display("chop accumulation test done");
        end_of_test;
    end
endmodule
